// [design/mt8_pkg.sv]
/*
  Shared constants and types for the 8-bit modulo timer: register
  offsets, field positions, reset values, clock-source codes, state.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
package mt8_pkg;

  // Register byte offsets
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_SC = 12'h000;
  localparam logic [11:0] OFS_CLK = 12'h004;
  localparam logic [11:0] OFS_CNT = 12'h008;
  localparam logic [11:0] OFS_WRAP = 12'h00C;
  localparam logic [11:0] OFS_GATE = 12'h010;

  // Field positions
  localparam int SC_OVF = 7;
  localparam int SC_IRQ_EN = 6;
  localparam int SC_TRST = 5;
  localparam int SC_HALT = 4;
  localparam int CLK_SRC_LSB = 4;
  localparam int GATE_EN = 0;

  // Prescale code that saturates the divider
  localparam logic [3:0] PSC_MAX = 4'h8;
  localparam logic [7:0] CNT_FULL = 8'hFF;

  // Reset values
  localparam logic [7:0] RST_CNT = 8'h00;
  localparam logic [7:0] RST_WRAP = 8'h00;
  localparam logic [3:0] RST_PSC = 4'h0;
  localparam logic RST_HALT = 1'b1;
  localparam logic RST_IRQ_EN = 1'b0;
  localparam logic RST_GATE = 1'b0;

  // Clock source codes in register order
  typedef enum logic [1:0] {SRC_BUS, SRC_FIXED, SRC_EXT_FALL, SRC_EXT_RISE} mt8_src_type;

  // Chip power and debug mode indications
  typedef struct packed {
    logic stop;
    logic debug;
    logic wake_rst;
  } mt8_mode_type;

  // Whole state of the timer top
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] wrap;
    logic flag;
    logic irq_en;
    logic halt;
    logic arm;
    mt8_src_type src;
    logic [3:0] psc_sel;
    logic gate;
    logic irq;
    logic [31:0] rdata;
  } mt8_st_type;

  localparam mt8_st_type ST_RST = '{cnt: RST_CNT, wrap: RST_WRAP, flag: 1'b0,
    irq_en: RST_IRQ_EN, halt: RST_HALT, arm: 1'b0, src: SRC_BUS, psc_sel: RST_PSC,
    gate: RST_GATE, irq: 1'b0, rdata: 32'h0000_0000};

  // Prescaler state
  typedef struct packed {
    logic [7:0] cnt;
  } mt8_psc_type;

  // Edge detector state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } mt8_edge_type;

endpackage

// [design/mt8_edge.sv]
/*
  Two-flop synchroniser with edge detection for a pin or foreign clock.
  Assumes the input toggles no faster than a quarter of the bus clock.
*/
`timescale 1ns/1ps
module mt8_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  mt8_pkg::mt8_edge_type q, d;

  // Shift chain; only the second stage reads the first
  always_comb begin
    d = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // One-cycle pulses from stages two and three
  assign rise = q.s2 & ~q.s3;
  assign fall = ~q.s2 & q.s3;

  a_rise_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    rise |=> !rise) else $error("edge pulse longer than one cycle");
endmodule

// [design/mt8_psc.sv]
/*
  Power-of-two prescaler for the selected timer source.
  Assumes src_tick is a one-cycle enable on the bus clock.
*/
`timescale 1ns/1ps
module mt8_psc (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic run,
  input wire logic src_tick,
  input wire logic [3:0] psc_sel,
  output logic tick
);
  mt8_pkg::mt8_psc_type q, d;
  logic [7:0] mask;

  // Mask of low divider bits; codes above eight divide by 256
  always_comb begin
    if (psc_sel >= mt8_pkg::PSC_MAX) begin
      mask = mt8_pkg::CNT_FULL;
    end else begin
      mask = 8'((9'h001 << psc_sel) - 9'h001);
    end
  end

  // Divider advances on source ticks; ratio change keeps the count
  always_comb begin
    d = q;
    if (clr) begin
      d.cnt = 8'h00;
    end else if (run && src_tick) begin
      d.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = run & src_tick & ~clr & ((q.cnt & mask) == mask);

  a_psc_max_div: assert property (@(posedge clk) disable iff (!rst_n)
    tick && psc_sel >= mt8_pkg::PSC_MAX |-> q.cnt == mt8_pkg::CNT_FULL)
    else $error("saturated prescale ticked early");
endmodule

// [design/mt8_timer.sv]
/*
  8-bit modulo timer with APB register access, source select,
  prescaler, overflow flag and interrupt, and power mode handling.
  Assumes APB master on SYS_CLK and mode inputs from the same clock.
*/
// The APB register port and the register offsets were chosen for this implementation.
// Notes on behaviour
// - Overflow flag sets on wrap to zero
// - Flag clears by status read then zero write
// - Counter clear or wrap write clears flag
// - Interrupt while flag and enable set
// - Clear bit zeroes count, reads zero
// - Halt bit freezes count; reset sets halt
// - Unused status and config bits read zero
// - Source field picks bus, fixed, tick edges
// - Source change keeps the count
// - Prescale divides by power of two, max 256
// - Prescale change keeps the count
// - Reset selects bus clock divided by one
// - Count register read-only, resets to zero
// - Wrap zero runs counter free
// - Wrap write stores, zeroes count, clears flag
// - Wait mode keeps an enabled timer counting
// - Stop mode disables counting, never wakes
// - Stop exit by reset restores reset state, gating bit kept
// - Debug suspends counting, resumes from held value
// - External tick synchronised, at most quarter rate
// - Chip gating bit enables timer, reset off
// - Count increments per tick, rolls after wrap
// - Overflow during clear sequence keeps flag set
`timescale 1ns/1ps
module mt8_timer #(
  parameter int ADDR_W = mt8_pkg::ADDR_W
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXTERNAL_TICK_INPUT,
  input wire logic FIXED_FREQUENCY_CLOCK,
  input wire mt8_pkg::mt8_mode_type CHIP_MODE,
  output logic TIMER_IRQ
);
  mt8_pkg::mt8_st_type q, d;
  logic ext_rise, ext_fall, fix_rise;
  logic setup, acc_wr, acc_rd;
  logic hit_sc, hit_clk, hit_cnt, hit_wrap, hit_gate, hit_any;
  logic trst_wr, wrap_wr, sw_clr, cnt_clr;
  logic active, src_tick, psc_tick, ovf;
  logic [7:0] top;
  logic [7:0] rd_byte;
  logic [1:0] src_field;

  // Pin and fixed clock pass two flops before edge detection
  mt8_edge u_ext (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .pin(EXTERNAL_TICK_INPUT),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  mt8_edge u_fix (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .pin(FIXED_FREQUENCY_CLOCK),
    .rise(fix_rise),
    .fall()
  );

  // APB phase and address decode
  always_comb begin
    setup = PSEL & ~PENABLE;
    acc_wr = PSEL & PENABLE & PWRITE;
    acc_rd = PSEL & PENABLE & ~PWRITE;
    hit_sc = PADDR == ADDR_W'(mt8_pkg::OFS_SC);
    hit_clk = PADDR == ADDR_W'(mt8_pkg::OFS_CLK);
    hit_cnt = PADDR == ADDR_W'(mt8_pkg::OFS_CNT);
    hit_wrap = PADDR == ADDR_W'(mt8_pkg::OFS_WRAP);
    hit_gate = PADDR == ADDR_W'(mt8_pkg::OFS_GATE);
    hit_any = hit_sc | hit_clk | hit_cnt | hit_wrap | hit_gate;
  end

  // Zero-wait slave; unmapped addresses answer with an error
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit_any;
  assign PRDATA = q.rdata;
  assign TIMER_IRQ = q.irq;

  // Write side effects; timer registers need the gating bit
  always_comb begin
    trst_wr = acc_wr & hit_sc & q.gate & PWDATA[mt8_pkg::SC_TRST];
    wrap_wr = acc_wr & hit_wrap & q.gate;
    sw_clr = acc_wr & hit_sc & q.gate & q.arm & ~PWDATA[mt8_pkg::SC_OVF];
    cnt_clr = trst_wr | wrap_wr;
  end

  // Source field of a configuration write
  assign src_field = PWDATA[mt8_pkg::CLK_SRC_LSB+1:mt8_pkg::CLK_SRC_LSB];

  // Counting runs only when clocked, not halted, not stopped or debugged
  // Wait mode has no term here, so an enabled timer keeps running
  assign active = q.gate & ~q.halt
    & ~CHIP_MODE.stop & ~CHIP_MODE.debug;

  // Source selection feeding the prescaler
  always_comb begin
    case (q.src)
      mt8_pkg::SRC_BUS: src_tick = 1'b1;
      mt8_pkg::SRC_FIXED: src_tick = fix_rise;
      mt8_pkg::SRC_EXT_FALL: src_tick = ext_fall;
      mt8_pkg::SRC_EXT_RISE: src_tick = ext_rise;
      default: src_tick = 1'b1;
    endcase
  end

  mt8_psc u_psc (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .clr(cnt_clr),
    .run(active),
    .src_tick(src_tick),
    .psc_sel(q.psc_sel),
    .tick(psc_tick)
  );

  // Wrap point; zero wrap value means full range
  assign top = (q.wrap == 8'h00) ? mt8_pkg::CNT_FULL : q.wrap;
  assign ovf = psc_tick & (q.cnt == top);

  // Read view of the addressed register
  always_comb begin
    rd_byte = 8'h00;
    if (hit_gate) begin
      rd_byte = {7'h00, q.gate};
    end else if (q.gate) begin
      if (hit_sc) begin
        rd_byte = {q.flag, q.irq_en, 1'b0, q.halt, 4'h0};
      end else if (hit_clk) begin
        rd_byte = {2'b00, q.src, q.psc_sel};
      end else if (hit_cnt) begin
        rd_byte = q.cnt;
      end else if (hit_wrap) begin
        rd_byte = q.wrap;
      end
    end
  end

  // Next state of the whole timer
  always_comb begin
    d = q;
    if (setup) begin
      d.rdata = {24'h00_0000, rd_byte};
    end
    // Counter: clear, else step on prescaled tick
    if (cnt_clr) begin
      d.cnt = 8'h00;
    end else if (psc_tick) begin
      d.cnt = ovf ? 8'h00 : q.cnt + 8'h01;
    end
    // Clear sequence armed by a status read with the flag set
    if (acc_rd && hit_sc && q.gate && q.flag) begin
      d.arm = 1'b1;
    end
    // A new overflow or any status write restarts the clear sequence
    if (ovf || (acc_wr && hit_sc) || cnt_clr) begin
      d.arm = 1'b0;
    end
    // Flag: hardware set wins over a software clear
    if (cnt_clr) begin
      d.flag = 1'b0;
    end else if (ovf) begin
      d.flag = 1'b1;
    end else if (sw_clr) begin
      d.flag = 1'b0;
    end
    // Status writes; the clear bit itself is never stored
    if (acc_wr && q.gate && hit_sc) begin
      d.irq_en = PWDATA[mt8_pkg::SC_IRQ_EN];
      d.halt = PWDATA[mt8_pkg::SC_HALT];
    end
    // Source and ratio change leave count and divider alone
    if (acc_wr && q.gate && hit_clk) begin
      d.src = mt8_pkg::mt8_src_type'(src_field);
      d.psc_sel = PWDATA[3:0];
    end
    // Wrap register; its write side effects sit with the counter
    if (wrap_wr) begin
      d.wrap = PWDATA[7:0];
    end
    if (acc_wr && hit_gate) begin
      d.gate = PWDATA[mt8_pkg::GATE_EN];
    end
    // Leaving stop through a reset path restores the reset state, keeping gate and read data
    if (CHIP_MODE.wake_rst) begin
      d = mt8_pkg::ST_RST;
      d.gate = q.gate;
      d.rdata = q.rdata;
    end
    // Registered request follows flag and enable
    d.irq = d.flag & d.irq_en;
  end

  // Reset gives halted, bus clock divided by one, gate off
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= mt8_pkg::ST_RST;
    end else begin
      q <= d;
    end
  end

  // Checks on the timer behaviour
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  // Overflow leaves count at zero with the flag up
  a_wrap_sets_flag: assert property (ovf && !cnt_clr && !CHIP_MODE.wake_rst
    |=> q.flag && q.cnt == 8'h00) else $error("wrap did not set flag");

  // Flag only drops for a known reason
  a_flag_fall_cause: assert property ($fell(q.flag) |->
    $past(sw_clr) || $past(cnt_clr) || $past(CHIP_MODE.wake_rst))
    else $error("flag cleared without cause");

  // Arming read with the flag up and no overflow
  a_clear_arms: assert property (acc_rd && hit_sc && q.gate && q.flag && !ovf
    && !cnt_clr && !CHIP_MODE.wake_rst |=> q.arm)
    else $error("status read did not arm clear");

  // Clear bit zeroes count and flag
  a_trst_clears: assert property (trst_wr && !CHIP_MODE.wake_rst
    |=> q.cnt == 8'h00 && !q.flag) else $error("clear bit ineffective");

  // Request is the registered AND of flag and enable
  a_irq_level: assert property (##1 TIMER_IRQ == (q.flag && q.irq_en))
    else $error("interrupt does not follow flag");

  // Clear bit and unused bits read as zero
  a_sc_read_zero: assert property (acc_rd && hit_sc |->
    PRDATA[5] == 1'b0 && PRDATA[3:0] == 4'h0)
    else $error("status unused bits not zero");

  // Halted count holds unless cleared
  a_halt_holds: assert property (q.halt && !cnt_clr && !CHIP_MODE.wake_rst
    |=> $stable(q.cnt)) else $error("count moved while halted");

  // Configuration unused bits read as zero
  a_clk_read_zero: assert property (acc_rd && hit_clk |->
    PRDATA[7:6] == 2'b00) else $error("config unused bits not zero");

  // Bus clock divided by one steps every cycle
  a_bus_div_one: assert property (active && q.src == mt8_pkg::SRC_BUS
    && q.psc_sel == 4'h0 && !cnt_clr && !CHIP_MODE.wake_rst && q.cnt != top
    |=> q.cnt == $past(q.cnt) + 8'h01) else $error("bus clock step missed");

  // Bus source gives a tick every cycle
  a_src_bus_tick: assert property (q.src == mt8_pkg::SRC_BUS |-> src_tick)
    else $error("bus source tick missing");

  // Rising-edge source follows the synchronised pin edge
  a_src_ext_rise: assert property (q.src == mt8_pkg::SRC_EXT_RISE
    |-> src_tick == ext_rise) else $error("tick edge source wrong");

  // Configuration write alone never moves the count
  a_cfg_keeps_cnt: assert property (acc_wr && q.gate && hit_clk && !psc_tick
    && !cnt_clr && !CHIP_MODE.wake_rst |=> $stable(q.cnt))
    else $error("config write moved count");

  // Configuration write stores the ratio code
  a_cfg_ratio: assert property (acc_wr && q.gate && hit_clk && !CHIP_MODE.wake_rst
    |=> q.psc_sel == $past(PWDATA[3:0])) else $error("ratio not stored");

  // Count register takes no write
  a_cnt_wr_ignored: assert property (acc_wr && hit_cnt && q.halt
    && !CHIP_MODE.wake_rst |=> $stable(q.cnt)) else $error("count took a write");

  // Wrap write stores value, zeroes count and flag
  a_wrap_write: assert property (wrap_wr && !CHIP_MODE.wake_rst |=>
    q.wrap == $past(PWDATA[7:0]) && q.cnt == 8'h00 && !q.flag)
    else $error("wrap write effects wrong");

  // Count never passes the wrap point
  a_count_range: assert property (q.cnt <= top)
    else $error("count beyond wrap point");

  // Stop and debug freeze the count
  a_stop_freeze: assert property ((CHIP_MODE.stop || CHIP_MODE.debug)
    && !cnt_clr && !CHIP_MODE.wake_rst |=> $stable(q.cnt))
    else $error("count moved in stop or debug");

  // Wake through reset path restores reset values
  a_wake_reset: assert property (CHIP_MODE.wake_rst |=>
    q.cnt == 8'h00 && q.halt && q.wrap == 8'h00 && !q.flag)
    else $error("stop exit reset incomplete");

  // Ungated timer neither counts nor shows its registers
  a_gate_off_hold: assert property (!q.gate && !CHIP_MODE.wake_rst
    |=> $stable(q.cnt)) else $error("ungated timer counted");

  a_gate_off_read: assert property (acc_rd && !q.gate && !hit_gate
    |-> PRDATA == 32'h0000_0000) else $error("ungated register visible");

  // Overflow beats a simultaneous software clear
  a_set_wins: assert property (ovf && sw_clr && !cnt_clr && !CHIP_MODE.wake_rst
    |=> q.flag) else $error("overflow lost to clear");

  // Main scenarios reached
  c_overflow: cover property (ovf && q.wrap != 8'h00);
  c_sw_clear: cover property (sw_clr ##1 !q.flag);
  c_ext_count: cover property (psc_tick && q.src == mt8_pkg::SRC_EXT_RISE);
  c_irq: cover property ($rose(TIMER_IRQ));
  c_debug_hold: cover property (CHIP_MODE.debug && q.gate && !q.halt);
endmodule

// [testbench/mt8_tick_src.sv]
/*
  Far-side model: fixed-frequency clock and external tick pin.
  Assumes the bench's clock and level requests on that clock.
*/
`timescale 1ns/1ps
module mt8_tick_src (
  input wire logic clk,
  input wire logic fix_on,
  input wire logic ext_req,
  output logic fix_clk,
  output logic ext_pin
);
  logic [1:0] fdiv = 2'h0;
  logic [1:0] hold = 2'h0;
  initial fix_clk = 1'b0;
  initial ext_pin = 1'b0;
  // Fixed clock toggles every 4 cycles while on; stands still otherwise
  always @(posedge clk) begin
    fdiv <= fdiv + 2'h1;
    if (fix_on && fdiv == 2'h3) begin
      fix_clk <= ~fix_clk;
    end
  end
  // Pin follows request, one change per 4 cycles at most
  always @(posedge clk) begin
    if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else if (ext_pin != ext_req) begin
      ext_pin <= ext_req;
      hold <= 2'h3;
    end
  end
endmodule

// [testbench/tb_eight_bit_modulo_timer.sv]
/*
  Self-checking bench for the 8-bit modulo timer over APB.
  Assumes zero-wait APB slave, mode inputs on SYS_CLK.
*/
`timescale 1ns/1ps
module tb_eight_bit_modulo_timer;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic irq, fix_on, ext_req, fix_clk, ext_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  mt8_pkg::mt8_mode_type mode;
  int mismatches, checks_done;
  mt8_timer u_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXTERNAL_TICK_INPUT(ext_pin), .FIXED_FREQUENCY_CLOCK(fix_clk),
    .CHIP_MODE(mode), .TIMER_IRQ(irq));
  mt8_tick_src u_src (.clk(sys_clk), .fix_on(fix_on), .ext_req(ext_req),
    .fix_clk(fix_clk), .ext_pin(ext_pin));
  // Bus clock, 4 ns
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // APB transfer: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rd, exp);
  endtask
  // Run with interrupt on until the request shows, then halt
  task automatic run_to_flag();
    int n;
    n = 0;
    apb(1'b1, mt8_pkg::OFS_SC, 32'h40); // flag is already clear here
    while (irq !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    check("irq", irq, 1'b1);
    apb(1'b1, mt8_pkg::OFS_SC, 32'h50);
  endtask
  task automatic t_reset();
    apb(1'b1, mt8_pkg::OFS_WRAP, 32'h05);
    rdchk(mt8_pkg::OFS_SC, 32'h00);
    apb(1'b1, mt8_pkg::OFS_GATE, 32'h01);
    rdchk(mt8_pkg::OFS_SC, 32'h10);
    rdchk(mt8_pkg::OFS_CLK, 32'h00);
    rdchk(mt8_pkg::OFS_CNT, 32'h00);
    rdchk(mt8_pkg::OFS_WRAP, 32'h00);
    rdchk(12'h020, 32'h00);
    check("slverr", err, 1'b1);
    apb(1'b1, mt8_pkg::OFS_CNT, 32'h55);
    rdchk(mt8_pkg::OFS_CNT, 32'h00);
    apb(1'b1, mt8_pkg::OFS_CLK, 32'hFF);
    rdchk(mt8_pkg::OFS_CLK, 32'h3F);
    apb(1'b1, mt8_pkg::OFS_CLK, 32'h00);
    apb(1'b1, mt8_pkg::OFS_SC, 32'h3F);
    rdchk(mt8_pkg::OFS_SC, 32'h10);
  endtask
  task automatic t_flag();
    apb(1'b1, mt8_pkg::OFS_WRAP, 32'h04);
    rdchk(mt8_pkg::OFS_WRAP, 32'h04);
    run_to_flag();
    apb(1'b0, mt8_pkg::OFS_CNT, 32'h0);
    check("cnt in range", rd <= 32'h04, 1'b1);
    rdchk(mt8_pkg::OFS_SC, 32'hD0);
    apb(1'b1, mt8_pkg::OFS_SC, 32'h50);
    rdchk(mt8_pkg::OFS_SC, 32'h50);
    check("irq cleared", irq, 1'b0);
    run_to_flag();
    apb(1'b1, mt8_pkg::OFS_SC, 32'h10);
    cyc(1);
    check("irq masked", irq, 1'b0);
    rdchk(mt8_pkg::OFS_SC, 32'h90);
    apb(1'b1, mt8_pkg::OFS_SC, 32'h30);
    rdchk(mt8_pkg::OFS_CNT, 32'h00);
    rdchk(mt8_pkg::OFS_SC, 32'h10);
    run_to_flag();
    apb(1'b1, mt8_pkg::OFS_WRAP, 32'h03);
    rdchk(mt8_pkg::OFS_SC, 32'h50);
    rdchk(mt8_pkg::OFS_CNT, 32'h00);
  endtask
  // Overflows keep coming between arming read and clearing write
  task automatic t_overrun();
    apb(1'b1, mt8_pkg::OFS_WRAP, 32'h01);
    apb(1'b1, mt8_pkg::OFS_SC, 32'h00);
    cyc(8);
    rdchk(mt8_pkg::OFS_SC, 32'h80);
    apb(1'b1, mt8_pkg::OFS_SC, 32'h00);
    rdchk(mt8_pkg::OFS_SC, 32'h80);
    apb(1'b1, mt8_pkg::OFS_SC, 32'h10);
  endtask
  task automatic t_free();
    logic [31:0] c;
    apb(1'b1, mt8_pkg::OFS_WRAP, 32'h00);
    apb(1'b1, mt8_pkg::OFS_SC, 32'h00);
    cyc(100);
    apb(1'b1, mt8_pkg::OFS_SC, 32'h10);
    apb(1'b0, mt8_pkg::OFS_CNT, 32'h0);
    c = rd;
    check("free run", c > 32'h60, 1'b1);
    cyc(30);
    rdchk(mt8_pkg::OFS_CNT, c);
    apb(1'b1, mt8_pkg::OFS_SC, 32'h00);
    apb(1'b1, mt8_pkg::OFS_CLK, 32'h18);
    apb(1'b0, mt8_pkg::OFS_CNT, 32'h0);
    check("count kept", rd >= c, 1'b1);
    apb(1'b1, mt8_pkg::OFS_SC, 32'h10);
  endtask
  // 32 steps expected for codes 0 to 9, window scaled by ratio
  task automatic t_prescale();
    for (int n = 0; n < 10; n++) begin
      apb(1'b1, mt8_pkg::OFS_CLK, n);
      apb(1'b1, mt8_pkg::OFS_SC, 32'h20);
      cyc(32 << ((n > 8) ? 8 : n));
      apb(1'b1, mt8_pkg::OFS_SC, 32'h10);
      apb(1'b0, mt8_pkg::OFS_CNT, 32'h0);
      check($sformatf("ratio %0d", n), rd >= 32'd31 && rd <= 32'd36, 1'b1);
    end
  endtask
  task automatic t_source();
    apb(1'b1, mt8_pkg::OFS_CLK, 32'h10);
    apb(1'b1, mt8_pkg::OFS_SC, 32'h20);
    fix_on <= 1'b1;
    cyc(128);
    fix_on <= 1'b0;
    apb(1'b1, mt8_pkg::OFS_SC, 32'h10);
    apb(1'b0, mt8_pkg::OFS_CNT, 32'h0);
    check("fixed", rd >= 32'd15 && rd <= 32'd17, 1'b1);
    for (int s = 2; s < 4; s++) begin
      apb(1'b1, mt8_pkg::OFS_CLK, s << 4);
      apb(1'b1, mt8_pkg::OFS_SC, 32'h20);
      ext_req <= 1'b1;
      cyc(10);
      rdchk(mt8_pkg::OFS_CNT, s == 3);
      ext_req <= 1'b0;
      cyc(10);
      rdchk(mt8_pkg::OFS_CNT, 32'h01);
    end
  endtask
  task automatic t_modes();
    logic [31:0] c;
    apb(1'b1, mt8_pkg::OFS_CLK, 32'h00);
    apb(1'b1, mt8_pkg::OFS_SC, 32'h00);
    for (int m = 0; m < 2; m++) begin
      mode <= 3'h4 >> m;
      cyc(4);
      apb(1'b0, mt8_pkg::OFS_CNT, 32'h0);
      c = rd;
      cyc(20);
      rdchk(mt8_pkg::OFS_CNT, c);
      mode <= 3'h0;
      cyc(10);
      apb(1'b0, mt8_pkg::OFS_CNT, 32'h0);
      check("resumed", rd != c, 1'b1);
    end
    mode <= 3'h1;
    cyc(1);
    mode <= 3'h0;
    rdchk(mt8_pkg::OFS_SC, 32'h10);
    rdchk(mt8_pkg::OFS_CNT, 32'h00);
  endtask
  // Reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fix_on = 1'b0;
    ext_req = 1'b0;
    mode = 3'h0;
    mismatches = 0;
    checks_done = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_flag();
    t_overrun();
    t_free();
    t_prescale();
    t_source();
    t_modes();
    final_report();
  end
  // Watchdog well beyond the expected run
  initial begin
    #240000;
    mismatches++;
    final_report();
  end
endmodule
